// *** hdl/gdc_regs.sv ***
// Notes on behaviour
// [RQ1] scheme field 00 six, 01 three, 10 single, 11 independent; resets 00
// [RQ2] bit 9 high masks charge pump undervoltage fault
// [RQ3] bit 8 high masks gate drive fault
// [RQ4] overheat warning reaches pin and summary only when bit 7 set
// [RQ5] single scheme: bit 4 low synchronous, high diode freewheel
// [RQ6] single scheme direction is bit 3 OR phase C high input
// [RQ7] bit 2 set puts all six gate outputs high impedance
// [RQ8] single scheme brake is bit 1 OR phase C low input
// [RQ9] writing bit 0 high clears latched faults, bit self clears
// [RQ10] 110 locks; locked writes only reach lock field and control bits 0-2
// [RQ11] unlocked, lock values other than 110 change nothing
// [RQ12] 011 unlocks; field resets to 011, bank starts unlocked
// [RQ13] locked, lock values other than 011 keep the lock
// [RQ14] high side source code 4 bits, resets to 1111
// [RQ15] high side sink code 4 bits, resets to 1111
// [RQ16] low side source and sink codes 4 bits, reset to 1111
// [RQ17] duration code selects 500, 1000, 2000, 4000 ns; resets 11
// [RQ18] bit 10 low side plus retry mode clears overcurrent on new pulse
// [RQ19] overcurrent response 01 is retry mode
// [RQ20] summary fault is OR of flags and mirrors the fault pin
// [RQ21] host programs settings before locking
`timescale 1ns/1ps
`default_nettype none
module gdc_regs (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// host register port, same clock domain
	input wire gdc_pkg::gdc_req_t req,
	output logic [10:0] rdata,
	output logic rvalid,
	// pins and detectors from outside the clock domain
	input wire logic phase_c_high_input,
	input wire logic phase_c_low_input,
	input wire logic bridge_pulse_in,
	input wire gdc_pkg::gdc_fault_in_t fault_in,
	input wire logic [1:0] overcurrent_response,
	// driver settings
	output gdc_pkg::gdc_scheme_t scheme,
	output logic gates_hiz,
	output logic all_low_on,
	output logic single_input_direction,
	output logic single_input_freewheel_select,
	output logic [3:0] high_side_source_current,
	output logic [3:0] high_side_sink_current,
	output logic [3:0] low_side_source_current,
	output logic [3:0] low_side_sink_current,
	output logic [7:0] peak_current_cycles,
	output logic locked,
	// fault reporting
	output logic pump_uv_flag,
	output logic gate_drive_fault_flag,
	output logic overcurrent_flag,
	output logic summary_fault,
	output logic fault_indicator_pin_n
);
	logic [10:0] ctrl_reg, ctrl_next;
	logic [10:0] hs_reg, hs_next;
	logic [10:0] ls_reg, ls_next;
	logic locked_reg, locked_next;
	logic [1:0] overcurrent_response_reg;
	logic [7:0] s1_reg, s2_reg;
	logic pulse_prev_reg;
	logic [2:0] pin_flags_reg;
	logic [2:0] flags_next;
	logic [10:0] rdata_reg;
	logic rvalid_reg, summary_reg, pin_n_reg;
	logic [3:0] gate_out_reg;
	logic [7:0] cycles_reg;

	// two-flop synchroniser on the pin and detector inputs; overcurrent_response gets a single flop
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s1_reg <= 8'h00;
			s2_reg <= 8'h00;
		end
		else
		begin
			s1_reg <= {phase_c_high_input, phase_c_low_input, bridge_pulse_in, fault_in};
			s2_reg <= s1_reg;
		end
	end

	wire hc_sync = s2_reg[7];
	wire lc_sync = s2_reg[6];
	wire pulse_sync = s2_reg[5];
	wire cpuv_sync = s2_reg[4];
	wire gdf_sync = s2_reg[3];
	wire otw_sync = s2_reg[2];
	wire ocp_sync = s2_reg[1] | s2_reg[0];
	wire pulse_rise = pulse_sync & ~pulse_prev_reg;

	// write decode
	wire wr_ctrl = req.wr && req.addr == gdc_pkg::ADDR_DRIVER_CONTROL;
	wire wr_hs = req.wr && req.addr == gdc_pkg::ADDR_HIGH_SIDE;
	wire wr_ls = req.wr && req.addr == gdc_pkg::ADDR_LOW_SIDE;
	wire [2:0] lock_wr = req.data[gdc_pkg::POS_LOCK_HI:gdc_pkg::POS_LOCK_LO];
	// [RQ10] lock write filter
	wire [10:0] ctrl_mask = locked_reg ? gdc_pkg::LOCKED_WRITE_MASK : 11'h7ff;
	wire [10:0] ctrl_wdata = (ctrl_reg & ~ctrl_mask) | (req.data & ctrl_mask);
	// [RQ11] lock code recognition
	wire do_lock = wr_hs && !locked_reg && lock_wr == gdc_pkg::LOCK_CODE;
	// [RQ13] unlock code recognition
	wire do_unlock = wr_hs && locked_reg && lock_wr == gdc_pkg::UNLOCK_CODE;
	// the lock field only ever holds one of the two codes
	wire [2:0] lock_field = locked_next ? gdc_pkg::LOCK_CODE : gdc_pkg::UNLOCK_CODE;

	// [RQ12] lock state update
	assign locked_next = do_lock ? 1'b1 : (do_unlock ? 1'b0 : locked_reg);
	// [RQ9] clear bit returns to zero after one cycle
	assign ctrl_next = wr_ctrl ? ctrl_wdata : (ctrl_reg & ~11'h001);
	// [RQ14] high side codes, lock field kept apart
	assign hs_next = {lock_field,
		(wr_hs && !locked_reg) ? req.data[7:0] : hs_reg[7:0]};
	// [RQ16] low side codes frozen while locked
	assign ls_next = (wr_ls && !locked_reg) ? req.data : ls_reg;

	// register storage
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_reg <= gdc_pkg::RST_DRIVER_CONTROL;
			hs_reg <= gdc_pkg::RST_HIGH_SIDE;
			ls_reg <= gdc_pkg::RST_LOW_SIDE;
			locked_reg <= 1'b0;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			hs_reg <= hs_next;
			ls_reg <= ls_next;
			locked_reg <= locked_next;
		end
	end

	// read path, unmapped addresses read zero
	wire [10:0] rd_mux = (req.addr == gdc_pkg::ADDR_DRIVER_CONTROL) ? ctrl_reg :
		(req.addr == gdc_pkg::ADDR_HIGH_SIDE) ? hs_reg :
		(req.addr == gdc_pkg::ADDR_LOW_SIDE) ? ls_reg : 11'h000;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rdata_reg <= 11'h000;
			rvalid_reg <= 1'b0;
		end
		else
		begin
			rvalid_reg <= req.rd;
			rdata_reg <= req.rd ? rd_mux : rdata_reg;
		end
	end

	// fault flag sources, pump and gate drive masked by their disable bits, overcurrent unmasked
	wire clear_now = ctrl_reg[gdc_pkg::POS_FAULT_CLEAR];
	// [RQ2] pump undervoltage gating
	wire cpuv_evt = cpuv_sync & ~ctrl_reg[gdc_pkg::POS_PUMP_UV_DIS];
	// [RQ3] gate drive fault gating
	wire gdf_evt = gdf_sync & ~ctrl_reg[gdc_pkg::POS_GATE_FAULT_DIS];
	// [RQ19] retry mode decode
	wire retry_mode = overcurrent_response_reg == gdc_pkg::OCP_RETRY;
	// [RQ18] cycle-by-cycle clear on a new bridge pulse
	wire cbc_clear = retry_mode & ls_reg[gdc_pkg::POS_CYCLE_RETRY] & pulse_rise;

	// set wins over clear so no event is lost
	assign flags_next[2] = cpuv_evt | (pin_flags_reg[2] & ~clear_now);
	assign flags_next[1] = gdf_evt | (pin_flags_reg[1] & ~clear_now);
	assign flags_next[0] = ocp_sync | (pin_flags_reg[0] & ~clear_now & ~cbc_clear);

	// [RQ4] overheat warning reaches summary only when reported
	wire otw_report = otw_sync & ctrl_reg[gdc_pkg::POS_OVERHEAT_REPORT];
	// [RQ20] summary of all flags
	wire summary_next = |flags_next | otw_report;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pin_flags_reg <= 3'h0;
			summary_reg <= 1'b0;
			pin_n_reg <= 1'b1;
			pulse_prev_reg <= 1'b0;
			overcurrent_response_reg <= 2'h0;
		end
		else
		begin
			pin_flags_reg <= flags_next;
			summary_reg <= summary_next;
			pin_n_reg <= ~summary_next; // own flop so the pin needs no gate after it
			pulse_prev_reg <= pulse_sync;
			overcurrent_response_reg <= overcurrent_response; // static config, sampled
		end
	end

	// scheme dependent controls, and coast for every scheme
	wire single_mode = ctrl_reg[gdc_pkg::POS_MODE_HI:gdc_pkg::POS_MODE_LO] == 2'h2;
	// [RQ6] direction is bit OR pin
	wire dir_next = single_mode & (ctrl_reg[gdc_pkg::POS_DIRECTION] | hc_sync);
	// [RQ8] brake is bit OR pin
	wire brake_next = single_mode & (ctrl_reg[gdc_pkg::POS_BRAKE] | lc_sync);
	// [RQ5] freewheel select
	wire freewheel_next = single_mode & ctrl_reg[gdc_pkg::POS_FREEWHEEL];
	// [RQ7] coast overrides brake; direction and freewheel still pass
	wire coast_next = ctrl_reg[gdc_pkg::POS_COAST];

	// [RQ17] duration code to cycle count
	wire [1:0] dur_code = ls_reg[gdc_pkg::POS_DURATION_HI:gdc_pkg::POS_DURATION_LO];
	wire [7:0] cycles_next = (dur_code == 2'h0) ? gdc_pkg::DURATION_0_CYC :
		(dur_code == 2'h1) ? gdc_pkg::DURATION_1_CYC :
		(dur_code == 2'h2) ? gdc_pkg::DURATION_2_CYC : gdc_pkg::DURATION_3_CYC;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			gate_out_reg <= 4'h0;
			cycles_reg <= gdc_pkg::DURATION_3_CYC;
		end
		else
		begin
			gate_out_reg <= {coast_next, brake_next & ~coast_next, dir_next, freewheel_next};
			cycles_reg <= cycles_next;
		end
	end

	// outputs, all from flip-flops
	// [RQ1] scheme decode
	assign scheme = gdc_pkg::gdc_scheme_t'(ctrl_reg[gdc_pkg::POS_MODE_HI:gdc_pkg::POS_MODE_LO]);
	assign gates_hiz = gate_out_reg[3];
	assign all_low_on = gate_out_reg[2];
	assign single_input_direction = gate_out_reg[1];
	assign single_input_freewheel_select = gate_out_reg[0];
	// [RQ15] sink and source code outputs
	assign high_side_source_current = hs_reg[7:4];
	assign high_side_sink_current = hs_reg[3:0];
	assign low_side_source_current = ls_reg[7:4];
	assign low_side_sink_current = ls_reg[3:0];
	assign peak_current_cycles = cycles_reg;
	assign locked = locked_reg;
	assign pump_uv_flag = pin_flags_reg[2];
	assign gate_drive_fault_flag = pin_flags_reg[1];
	assign overcurrent_flag = pin_flags_reg[0];
	// pin is active low, loaded on the same edge as the summary bit
	assign summary_fault = summary_reg;
	assign fault_indicator_pin_n = pin_n_reg;
	assign rdata = rdata_reg;
	assign rvalid = rvalid_reg;

	// checks
	lock_takes_a: assert property (@(posedge clk) disable iff (rst) // [RQ10]
		(req.wr && req.addr == gdc_pkg::ADDR_HIGH_SIDE && !locked
			&& req.data[10:8] == 3'h6) |=> locked)
		else $error("lock code did not lock");
	locked_ls_a: assert property (@(posedge clk) disable iff (rst) // [RQ10]
		(locked && $past(locked)) |-> $stable(ls_reg))
		else $error("low side changed while locked");
	unlock_only_a: assert property (@(posedge clk) disable iff (rst) // [RQ13]
		(locked && !(req.wr && req.addr == gdc_pkg::ADDR_HIGH_SIDE
			&& req.data[10:8] == 3'h3)) |=> locked)
		else $error("lock lost without unlock code");
	stay_unlock_a: assert property (@(posedge clk) disable iff (rst) // [RQ11]
		(!locked && !(req.wr && req.addr == gdc_pkg::ADDR_HIGH_SIDE
			&& req.data[10:8] == 3'h6)) |=> !locked)
		else $error("lock taken without lock code");
	clear_self_a: assert property (@(posedge clk) disable iff (rst) // [RQ9]
		ctrl_reg[0] && !wr_ctrl |=> !ctrl_reg[0])
		else $error("clear bit did not self clear");
	clear_flag_a: assert property (@(posedge clk) disable iff (rst) // [RQ9]
		(ctrl_reg[0] && !cpuv_evt) |=> !pump_uv_flag)
		else $error("pump flag survived clear");
	coast_hiz_a: assert property (@(posedge clk) disable iff (rst) // [RQ7]
		ctrl_reg[2] |=> gates_hiz && !all_low_on)
		else $error("coast did not float gates");
	gdf_mask_a: assert property (@(posedge clk) disable iff (rst) // [RQ3]
		(ctrl_reg[8] && !gate_drive_fault_flag && !ctrl_reg[0]) |=> !gate_drive_fault_flag)
		else $error("gate fault raised while disabled");
	brake_pin_a: assert property (@(posedge clk) disable iff (rst) // [RQ8]
		(ctrl_reg[6:5] == 2'h2 && lc_sync && !ctrl_reg[2]) |=> all_low_on)
		else $error("brake pin ignored in single scheme");
	cbc_clear_a: assert property (@(posedge clk) disable iff (rst) // [RQ18]
		(cbc_clear && !ocp_sync) |=> !overcurrent_flag)
		else $error("retry clear missed");
	summary_pin_a: assert property (@(posedge clk) disable iff (rst) // [RQ20]
		(fault_indicator_pin_n != summary_fault) && (summary_fault == (pump_uv_flag
			|| gate_drive_fault_flag || overcurrent_flag || $past(otw_report))))
		else $error("summary and pin disagree");
	pump_mask_a: assert property (@(posedge clk) disable iff (rst) // [RQ2]
		(ctrl_reg[9] && !pump_uv_flag) |=> !pump_uv_flag)
		else $error("pump fault raised while disabled");
	freewheel_sel_a: assert property (@(posedge clk) disable iff (rst) // [RQ5]
		(ctrl_reg[6:5] == 2'h2) |=> single_input_freewheel_select == $past(ctrl_reg[4]))
		else $error("freewheel select wrong in single scheme");
	direction_or_a: assert property (@(posedge clk) disable iff (rst) // [RQ6]
		(ctrl_reg[6:5] == 2'h2 && (hc_sync || ctrl_reg[3])) |=> single_input_direction)
		else $error("direction bit or pin ignored");
	locked_hs_a: assert property (@(posedge clk) disable iff (rst) // [RQ10]
		(locked && $past(locked)) |-> $stable(hs_reg[7:0]))
		else $error("high side codes changed while locked");
	duration_map_a: assert property (@(posedge clk) disable iff (rst) // [RQ17]
		peak_current_cycles == (gdc_pkg::DURATION_0_CYC << $past(ls_reg[9:8])))
		else $error("peak duration count wrong");
endmodule // gdc_regs
`default_nettype wire

// *** include/gdc_pkg.sv ***
`default_nettype none
package gdc_pkg;
	// register addresses
	localparam logic [3:0] ADDR_DRIVER_CONTROL = 4'h2;
	localparam logic [3:0] ADDR_HIGH_SIDE = 4'h3;
	localparam logic [3:0] ADDR_LOW_SIDE = 4'h4;
	localparam int DATA_W = 11;

	// reset values
	localparam logic [10:0] RST_DRIVER_CONTROL = 11'h000;
	localparam logic [10:0] RST_HIGH_SIDE = 11'h3ff;
	localparam logic [10:0] RST_LOW_SIDE = 11'h7ff;

	// driver control fields
	localparam int POS_PUMP_UV_DIS = 9;
	localparam int POS_GATE_FAULT_DIS = 8;
	localparam int POS_OVERHEAT_REPORT = 7;
	localparam int POS_MODE_HI = 6;
	localparam int POS_MODE_LO = 5;
	localparam int POS_FREEWHEEL = 4;
	localparam int POS_DIRECTION = 3;
	localparam int POS_COAST = 2;
	localparam int POS_BRAKE = 1;
	localparam int POS_FAULT_CLEAR = 0;
	// bits still writable on driver control while locked
	localparam logic [10:0] LOCKED_WRITE_MASK = 11'h007;

	// high side fields
	localparam int POS_LOCK_HI = 10;
	localparam int POS_LOCK_LO = 8;
	localparam logic [10:0] LOCK_FIELD_MASK = 11'h700;
	localparam logic [2:0] LOCK_CODE = 3'h6;
	localparam logic [2:0] UNLOCK_CODE = 3'h3;

	// low side fields
	localparam int POS_CYCLE_RETRY = 10;
	localparam int POS_DURATION_HI = 9;
	localparam int POS_DURATION_LO = 8;

	// overcurrent response code for automatic retry
	localparam logic [1:0] OCP_RETRY = 2'h1;

	// peak current durations
	localparam int CLK_PERIOD_NS = 20;
	localparam int DURATION_0_NS = 500;
	localparam int DURATION_1_NS = 1000;
	localparam int DURATION_2_NS = 2000;
	localparam int DURATION_3_NS = 4000;
	localparam logic [7:0] DURATION_0_CYC = 8'(DURATION_0_NS / CLK_PERIOD_NS);
	localparam logic [7:0] DURATION_1_CYC = 8'(DURATION_1_NS / CLK_PERIOD_NS);
	localparam logic [7:0] DURATION_2_CYC = 8'(DURATION_2_NS / CLK_PERIOD_NS);
	localparam logic [7:0] DURATION_3_CYC = 8'(DURATION_3_NS / CLK_PERIOD_NS);

	// bridge input schemes
	typedef enum logic [1:0] {
		GDC_SIX_INPUT,
		GDC_THREE_INPUT,
		GDC_SINGLE_INPUT,
		GDC_INDEPENDENT
	} gdc_scheme_t;

	// host register request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [10:0] data;
	} gdc_req_t;

	// raw fault detector events
	typedef struct packed {
		logic pump_undervoltage;
		logic gate_drive_fault;
		logic overheat_warning;
		logic drain_source_overcurrent;
		logic sense_overcurrent;
	} gdc_fault_in_t;
endpackage
`default_nettype wire

// *** verification/gdc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module gdc_host (
	// clock
	input wire logic clk,
	// register port, host side
	output var gdc_pkg::gdc_req_t req,
	input wire logic [10:0] rdata,
	input wire logic rvalid
);
	// idle port at time zero
	initial req = '0;

	// one write, taken at the rising edge after the request goes up
	task automatic write_reg(input logic [3:0] a, input logic [10:0] d);
		@(negedge clk);
		req = '{1'b1, 1'b0, a, d};
		@(negedge clk);
		// released lines flip so a stale value is never mistaken for data
		req = '{1'b0, 1'b0, ~a, ~d};
	endtask

	// one read; rvalid stands only in the cycle after the take, rdata holds until the next read
	task automatic read_reg(input logic [3:0] a, output logic [10:0] d, output logic v);
		@(negedge clk);
		req = '{1'b0, 1'b1, a, 11'h000};
		@(negedge clk);
		v = rvalid;
		d = rdata;
		req = '{1'b0, 1'b0, ~a, 11'h7ff};
	endtask
endmodule // gdc_host
`default_nettype wire

// *** verification/gdc_regs_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module gdc_regs_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	gdc_pkg::gdc_req_t req;
	gdc_pkg::gdc_fault_in_t flt = '0;
	gdc_pkg::gdc_scheme_t scheme;
	logic [10:0] rdata, rd_val;
	logic rvalid, rd_ok, hiz, low_on, dir, fw, lk, pu, gd, oc, sf, pin_n;
	logic dir_in = 1'b0, brake_in = 1'b0, pulse_in = 1'b0;
	logic [1:0] ocr = 2'h0;
	logic [3:0] hsp, hsn, lsp, lsn;
	logic [7:0] pk;
	int errors = 0, check_count = 0, cycles = 0;
	// single scheme table: control word, {direction pin, brake pin}, {dir, low, fw, hiz}
	logic [10:0] sc_ctrl [9] = '{11'h040, 11'h040, 11'h048, 11'h042, 11'h040, 11'h050, 11'h046, 11'h00a, 11'h004};
	logic [1:0] sc_pin [9] = '{2'h0, 2'h2, 2'h0, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h0};
	logic [3:0] sc_exp [9] = '{4'h0, 4'h8, 4'h8, 4'h4, 4'h4, 4'h2, 4'h1, 4'h0, 4'h1};
	// fault table: control word, detector inputs, {pu, gd, oc, summary, pin_n}
	logic [10:0] fc_ctrl [8] = '{11'h000, 11'h200, 11'h000, 11'h100, 11'h000, 11'h080, 11'h000, 11'h000};
	logic [4:0] fc_in [8] = '{5'h10, 5'h10, 5'h08, 5'h08, 5'h04, 5'h04, 5'h02, 5'h01};
	logic [4:0] fc_exp [8] = '{5'h12, 5'h01, 5'h0a, 5'h01, 5'h01, 5'h02, 5'h06, 5'h06};

	gdc_regs gdc_regs_inst (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
		.phase_c_high_input(dir_in), .phase_c_low_input(brake_in), .bridge_pulse_in(pulse_in),
		.fault_in(flt), .overcurrent_response(ocr), .scheme(scheme), .gates_hiz(hiz),
		.all_low_on(low_on), .single_input_direction(dir), .single_input_freewheel_select(fw),
		.high_side_source_current(hsp), .high_side_sink_current(hsn),
		.low_side_source_current(lsp), .low_side_sink_current(lsn), .peak_current_cycles(pk),
		.locked(lk), .pump_uv_flag(pu), .gate_drive_fault_flag(gd), .overcurrent_flag(oc),
		.summary_fault(sf), .fault_indicator_pin_n(pin_n));
	gdc_host gdc_host_inst (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

	// clock and hang guard; the tests need well under a thousand cycles
	always #10 clk = ~clk;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			errors++;
			$display("unexpected %0t run did not finish", $time);
			end_sim;
		end
	end

	task automatic end_sim;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [10:0] d);
		gdc_host_inst.write_reg(a, d);
	endtask

	task automatic rchk(input logic [3:0] a, input logic [10:0] exp);
		gdc_host_inst.read_reg(a, rd_val, rd_ok);
		chk({10'h0, rd_ok}, 11'h001, "read answer");
		chk(rd_val, exp, "read data");
	endtask

	task automatic nclk(input int n);
		repeat (n) @(negedge clk);
	endtask

	initial
	begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		rchk(4'h2, 11'h000);
		rchk(4'h3, 11'h3ff);
		rchk(4'h4, 11'h7ff);
		rchk(4'h5, 11'h000);
		chk({3'h0, pk}, 11'd200, "reset duration");
		chk({10'h0, lk}, 11'h000, "reset lock");
		$display("test reset done");
		for (int m = 0; m < 4; m++)
		begin
			wr(4'h2, 11'(m << 5));
			chk({9'h0, scheme}, 11'(m), "scheme");
		end
		for (int t = 0; t < 4; t++)
		begin
			wr(4'h4, {1'b0, 2'(t), 8'h5c});
			nclk(1);
			chk({3'h0, pk}, 11'(500 * (1 << t) / 20), "duration");
			chk({3'h0, lsp, lsn}, 11'h05c, "low codes");
		end
		wr(4'h3, 11'h3a5);
		chk({3'h0, hsp, hsn}, 11'h0a5, "high codes");
		$display("test settings done");
		for (int i = 0; i < 9; i++)
		begin
			wr(4'h2, sc_ctrl[i]);
			{dir_in, brake_in} = sc_pin[i];
			nclk(4);
			chk({7'h0, dir, low_on, fw, hiz}, {7'h0, sc_exp[i]}, "drive mode");
		end
		{dir_in, brake_in} = 2'h0;
		$display("test single scheme done");
		for (int i = 0; i < 8; i++)
		begin
			wr(4'h2, fc_ctrl[i]);
			flt = fc_in[i];
			nclk(4);
			chk({6'h0, pu, gd, oc, sf, pin_n}, {6'h0, fc_exp[i]}, "fault");
			flt = '0;
			nclk(2);
			wr(4'h2, fc_ctrl[i] | 11'h001);
			nclk(2);
			chk({6'h0, pu, gd, oc, sf, pin_n}, 11'h001, "cleared");
			rchk(4'h2, fc_ctrl[i]);
		end
		$display("test faults done");
		wr(4'h4, 11'h75c);
		for (int i = 0; i < 2; i++)
		begin
			ocr = i ? 2'h0 : 2'h1;
			pulse_in = 1'b0;
			flt = 5'h02;
			nclk(4);
			flt = '0;
			nclk(3);
			chk({10'h0, oc}, 11'h001, "overcurrent held");
			pulse_in = 1'b1;
			nclk(4);
			chk({10'h0, oc}, 11'(i), "overcurrent after pulse");
			wr(4'h2, 11'h001);
			nclk(2);
		end
		$display("test retry done");
		// settings are all in place before the lock code goes in
		wr(4'h3, 11'h5aa);
		rchk(4'h3, 11'h3aa);
		wr(4'h3, 11'h6aa);
		chk({10'h0, lk}, 11'h001, "locked");
		wr(4'h4, 11'h123);
		rchk(4'h4, 11'h75c);
		wr(4'h2, 11'h7fe);
		rchk(4'h2, 11'h006);
		wr(4'h3, 11'h255);
		rchk(4'h3, 11'h6aa);
		wr(4'h3, 11'h3aa);
		rchk(4'h3, 11'h3aa);
		wr(4'h4, 11'h123);
		rchk(4'h4, 11'h123);
		$display("test lock done");
		end_sim;
	end
endmodule // gdc_regs_test
`default_nettype wire
